// [rtl/spc_config_regs.sv]
// configuration register bank of one switch port: eeprom word and express cap
`timescale 1ns/1ps

// Function
// R1: writing start launches one eeprom access
// R2: command bit selects read or write
// R3: missing eeprom acknowledge sets error flag
// R4: autoload success flag clears when read
// R5: autoload status shows autoload succeeded
// R6: autoload disable bit, resets to one
// R7: eeprom clock rate field, resets to 01b
// R8: eeprom word address from bits 15:9
// R9: data field feeds writes, captures reads
// R10: fixed capability id, pointer and version
// R11: port type upstream 0101b, downstream 0110b
// R12: slot implemented from strap, overridable
// R13: interrupt message number reads zero
// R14: supported payload from strap, overridable
// R15: phantom, extended tag, latencies read zero
// R16: role based error reporting resets one
// R17: upstream captures slot power limit messages
// R18: four error reporting enables, reset zero
// R19: oversize payload write clamps to supported
// R20: ordering, snoop, tag, read size zero
// R21: aux power enable sticky across resets
// R22: error detected flags, write one clears
// R23: hardware clears start when access completes
// R24: aux detected reads one, pending zero
module spc_config_regs #(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int EE_ADDR_W   = 7
) (
  input  wire logic                   clk_in,           // core clock
  input  wire logic                   resetn_in,        // fundamental reset
  input  wire logic                   por_resetn_in,    // power-on reset
  input  wire logic                   ce_in,            // clock enable
  input  wire spc_pkg::spc_cfg_req_s  cfg_req_in,       // config access
  output logic [31:0]                 cfg_rdata_out,    // read data
  output logic                        cfg_rvalid_out,   // read data valid
  input  wire spc_pkg::spc_ee_resp_s  ee_resp_in,       // eeprom engine result
  output logic                        ee_start_out,     // access request
  output logic                        ee_write_out,     // 1 write, 0 read
  output logic [EE_ADDR_W-1:0]        ee_addr_out,      // eeprom word addr
  output logic [15:0]                 ee_wdata_out,     // eeprom write word
  output logic [1:0]                  ee_rate_out,      // eeprom clock rate
  output logic                        autoload_disable_out, // autoload off
  input  wire spc_pkg::spc_autoload_s al_in,            // autoload / smbus
  input  wire spc_pkg::spc_spl_msg_s  spl_msg_in,       // slot power msg
  input  wire logic [3:0]             err_detect_in,    // error pulses
  input  wire logic                   slot_present_strap_in, // slot strap pin
  input  wire logic                   large_payload_strap_in, // payload strap
  output logic [3:0]                  err_report_en_out, // report enables
  output logic [2:0]                  max_payload_out,  // programmed payload
  output logic                        aux_pm_en_out     // aux power enable
);

  if (EE_ADDR_W != 7) begin : g_chk
    $error("EE_ADDR_W must be 7");
  end

  // byte-lane merge of a config write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // write hit on a dword, whichever lanes are enabled
  function automatic logic hit(input spc_pkg::spc_cfg_req_s q,
                               input logic [7:0] off);
    return q.wr && (q.addr == off);
  endfunction

  // strap synchronisers
  logic [1:0] slot_sync;
  logic [1:0] pl_sync;
  logic [1:0] settle;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slot_sync <= 2'h0;
      pl_sync   <= 2'h0;
    end else if (ce_in) begin
      slot_sync <= {slot_sync[0], slot_present_strap_in};
      pl_sync   <= {pl_sync[0], large_payload_strap_in};
    end
  end

  // straps are caught after release, once the synchronisers have filled
  // the count covers both stages, or the capture would read reset zeros
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settle <= spc_pkg::STRAP_SETTLE;
    end else if (ce_in && settle != 2'h0) begin
      settle <= settle - 2'h1;
    end
  end

  wire logic strap_load = (settle == 2'h1);

  // eeprom access word
  logic                 ee_start;
  logic                 ee_cmd;
  logic                 ee_err;
  logic                 al_ok;
  logic                 al_status;
  logic                 al_dis;
  logic [1:0]           ee_rate;
  logic [EE_ADDR_W-1:0] ee_addr;
  logic [15:0]          ee_data;

  // bit 8 is reserved and reads zero; a done seen while idle is
  // ignored, so a late engine pulse cannot end a new access

  logic [31:0] ee_cur;
  always_comb begin
    ee_cur = 32'h0;
    ee_cur[spc_pkg::EE_START_BIT] = ee_start;
    ee_cur[spc_pkg::EE_CMD_BIT]   = ee_cmd;
    ee_cur[spc_pkg::EE_ERR_BIT]   = ee_err;
    ee_cur[spc_pkg::EE_ALOK_BIT]  = al_ok;
    ee_cur[spc_pkg::EE_ALST_BIT]  = al_status;
    ee_cur[spc_pkg::EE_ALDIS_BIT] = al_dis;
    ee_cur[spc_pkg::EE_RATE_LSB +: 2] = ee_rate;
    ee_cur[spc_pkg::EE_ADDR_LSB +: EE_ADDR_W] = ee_addr;
    ee_cur[spc_pkg::EE_DATA_LSB +: 16] = ee_data;
  end

  wire logic        ee_wr  = IS_UPSTREAM && hit(cfg_req_in, spc_pkg::OFF_EEPROM);
  wire logic [31:0] ee_new = merge(ee_cur, cfg_req_in.wdata, cfg_req_in.be);
  wire logic        ee_fin = ee_start && ee_resp_in.done;
  wire logic        ee_launch = ee_wr && !ee_start
                                && ee_new[spc_pkg::EE_START_BIT];

  // start, command and completion
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ee_start <= 1'b0;
      ee_cmd   <= 1'b0;
    end else if (ce_in) begin
      if (ee_fin) begin
        ee_start <= 1'b0;                                        // R23
      end else if (ee_launch) begin
        ee_start <= 1'b1;                                        // R1
      end
      // command is held while a cycle runs so the engine sees one type
      if (ee_wr && !ee_start) begin
        ee_cmd <= ee_new[spc_pkg::EE_CMD_BIT];                   // R2
      end
    end
  end

  // acknowledge error: cleared by a new launch, set by a failed cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ee_err <= 1'b0;
    end else if (ce_in) begin
      if (ee_fin && ee_resp_in.nack) begin
        ee_err <= 1'b1;                                          // R3
      end else if (ee_launch) begin
        ee_err <= 1'b0;
      end
    end
  end

  // autoload flags; a successful completion in the same cycle as the read wins
  wire logic ee_rd_clr = IS_UPSTREAM && cfg_req_in.rd
                         && cfg_req_in.addr == spc_pkg::OFF_EEPROM
                         && cfg_req_in.be[0];
  wire logic al_good = al_in.done && al_in.ok && !al_dis;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      al_ok     <= 1'b0;
      al_status <= 1'b0;
    end else if (ce_in) begin
      if (al_good) begin
        al_ok <= 1'b1;                                           // R4
      end else if (ee_rd_clr) begin
        al_ok <= 1'b0;                                           // R4
      end
      if (al_in.done) begin
        al_status <= al_good;                                    // R5
      end
    end
  end

  // software fields of the access word
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      al_dis  <= spc_pkg::EE_ALDIS_RST;                          // R6
      ee_rate <= spc_pkg::EE_RATE_RST;                           // R7
      ee_addr <= '0;
    end else if (ce_in && ee_wr) begin
      al_dis  <= ee_new[spc_pkg::EE_ALDIS_BIT];                  // R6
      ee_rate <= ee_new[spc_pkg::EE_RATE_LSB +: 2];              // R7
      // address is frozen during a cycle to keep the access coherent
      if (!ee_start) begin
        ee_addr <= ee_new[spc_pkg::EE_ADDR_LSB +: EE_ADDR_W];    // R8
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ee_data <= 16'h0000;
    end else if (ce_in) begin
      if (ee_fin && !ee_cmd) begin
        ee_data <= ee_resp_in.rdata;                             // R9
      end else if (ee_wr) begin
        ee_data <= ee_new[spc_pkg::EE_DATA_LSB +: 16];           // R9
      end
    end
  end

  // hardware-initialised capability bits
  logic       slot_impl;
  logic [2:0] mps_sup;
  logic       rber;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      slot_impl <= 1'b0;
      mps_sup   <= spc_pkg::MPS_SUP_SMALL;
      rber      <= spc_pkg::RBER_RST;                            // R16
    end else if (ce_in) begin
      if (al_in.ovr_valid) begin
        slot_impl <= al_in.slot_impl;                            // R12
        mps_sup   <= al_in.mps_sup;                              // R14
        rber      <= al_in.rber;                                 // R16
      end else if (strap_load) begin
        slot_impl <= slot_sync[1];                               // R12
        mps_sup   <= pl_sync[1] ? spc_pkg::MPS_SUP_LARGE
                                : spc_pkg::MPS_SUP_SMALL;        // R14
      end
    end
  end

  // captured slot power limit, upstream only
  logic [7:0] spl_value;
  logic [1:0] spl_scale;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      spl_value <= 8'h00;
      spl_scale <= 2'h0;
    end else if (ce_in && IS_UPSTREAM && spl_msg_in.valid) begin
      spl_value <= spl_msg_in.value;                             // R17
      spl_scale <= spl_msg_in.scale;                             // R17
    end
  end

  // device control
  logic [3:0] rep_en;
  logic [2:0] mps;
  logic       aux_en;

  wire logic        dc_wr  = hit(cfg_req_in, spc_pkg::OFF_DEV_CTL);
  wire logic [31:0] dc_new = merge(32'h0, cfg_req_in.wdata, cfg_req_in.be);
  wire logic [2:0]  mps_wr = dc_new[spc_pkg::DCTL_MPS_LSB +: 3];
  // a later lower supported size does not re-clamp a stored value

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rep_en <= 4'h0;
      mps    <= spc_pkg::MPS_RST;
    end else if (ce_in && dc_wr && cfg_req_in.be[0]) begin
      rep_en <= dc_new[3:0];                                     // R18
      mps    <= (mps_wr > mps_sup) ? mps_sup : mps_wr;           // R19
    end
  end

  // sticky: only power-on reset clears it
  always_ff @(posedge clk_in or negedge por_resetn_in) begin
    if (!por_resetn_in) begin
      aux_en <= 1'b0;
    end else if (ce_in && dc_wr && cfg_req_in.be[1]) begin
      aux_en <= dc_new[spc_pkg::DCTL_AUX_BIT];                   // R21
    end
  end

  // error detected flags; a detection beats a clear in the same cycle
  // a lost detection would be worse than a lost clear
  logic [3:0] err_det;
  wire logic [3:0] err_clr = (dc_wr && cfg_req_in.be[2])
                             ? dc_new[spc_pkg::DSTS_ERR_LSB +: 4] : 4'h0;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_det <= 4'h0;
    end else if (ce_in) begin
      err_det <= (err_det & ~err_clr) | err_detect_in;           // R22
    end
  end

  // read multiplexer
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (cfg_req_in.addr)
      spc_pkg::OFF_EEPROM: begin
        rd_mux = IS_UPSTREAM ? ee_cur : 32'h0;
      end
      spc_pkg::OFF_CAP_HDR: begin
        rd_mux[7:0] = spc_pkg::CAP_ID;                           // R10
        rd_mux[spc_pkg::CAP_NEXT_LSB +: 8] = spc_pkg::CAP_NEXT;  // R10
        rd_mux[spc_pkg::CAP_VER_LSB +: 4] = spc_pkg::CAP_VER;    // R10
        rd_mux[spc_pkg::CAP_TYPE_LSB +: 4] = IS_UPSTREAM
          ? spc_pkg::PORT_TYPE_UP : spc_pkg::PORT_TYPE_DN;       // R11
        rd_mux[spc_pkg::CAP_SLOT_BIT] = slot_impl;               // R12
        // message number bits 29:25 stay zero                   // R13
      end
      spc_pkg::OFF_DEV_CAP: begin
        rd_mux[2:0] = mps_sup;                                   // R14
        // phantom, ext tag and latency fields stay zero         // R15
        rd_mux[spc_pkg::DCAP_RBER_BIT] = rber;                   // R16
        rd_mux[spc_pkg::DCAP_SPLV_LSB +: 8] = spl_value;         // R17
        rd_mux[spc_pkg::DCAP_SPLS_LSB +: 2] = spl_scale;         // R17
      end
      spc_pkg::OFF_DEV_CTL: begin
        rd_mux[3:0] = rep_en;                                    // R18
        rd_mux[spc_pkg::DCTL_MPS_LSB +: 3] = mps;                // R19
        // ordering, snoop, tag, phantom and read size read zero // R20
        rd_mux[spc_pkg::DCTL_AUX_BIT] = aux_en;                  // R21
        rd_mux[spc_pkg::DSTS_ERR_LSB +: 4] = err_det;            // R22
        rd_mux[spc_pkg::DSTS_AUXD_BIT] = spc_pkg::AUX_DET_RST;   // R24
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_rdata_out  <= 32'h0;
      cfg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      cfg_rvalid_out <= cfg_req_in.rd;
      if (cfg_req_in.rd) begin
        cfg_rdata_out <= rd_mux;
      end
    end
  end

  // engine and control outputs come straight from their registers
  assign ee_start_out         = ee_start;
  assign ee_write_out         = ee_cmd;
  assign ee_addr_out          = ee_addr;
  assign ee_wdata_out         = ee_data;
  assign ee_rate_out          = ee_rate;
  assign autoload_disable_out = al_dis;
  assign err_report_en_out    = rep_en;
  assign max_payload_out      = mps;
  assign aux_pm_en_out        = aux_en;

endmodule

// [rtl/spc_pkg.sv]
// shared constants and carrier types for the switch port config bank
package spc_pkg;

  // dword offsets inside the configuration space
  localparam logic [7:0] OFF_EEPROM   = 8'hBC;
  localparam logic [7:0] OFF_CAP_HDR  = 8'hC0;
  localparam logic [7:0] OFF_DEV_CAP  = 8'hC4;
  localparam logic [7:0] OFF_DEV_CTL  = 8'hC8;

  // eeprom access word fields
  localparam int EE_START_BIT  = 0;
  localparam int EE_CMD_BIT    = 1;
  localparam int EE_ERR_BIT    = 2;
  localparam int EE_ALOK_BIT   = 3;
  localparam int EE_ALST_BIT   = 4;
  localparam int EE_ALDIS_BIT  = 5;
  localparam int EE_RATE_LSB   = 6;
  localparam int EE_ADDR_LSB   = 9;
  localparam int EE_DATA_LSB   = 16;

  // capability header fields
  localparam int CAP_NEXT_LSB  = 8;
  localparam int CAP_VER_LSB   = 16;
  localparam int CAP_TYPE_LSB  = 20;
  localparam int CAP_SLOT_BIT  = 24;

  // device capability, control and status fields
  localparam int DCAP_RBER_BIT = 15;
  localparam int DCAP_SPLV_LSB = 18;
  localparam int DCAP_SPLS_LSB = 26;
  localparam int DCTL_MPS_LSB  = 5;
  localparam int DCTL_AUX_BIT  = 10;
  localparam int DSTS_ERR_LSB  = 16;
  localparam int DSTS_AUXD_BIT = 20;

  // fixed and reset values
  localparam logic [1:0] EE_RATE_RST   = 2'h1;
  localparam logic       EE_ALDIS_RST  = 1'b1;
  localparam logic [7:0] CAP_ID        = 8'h10;
  localparam logic [7:0] CAP_NEXT      = 8'h00;
  localparam logic [3:0] CAP_VER       = 4'h2;
  localparam logic [3:0] PORT_TYPE_UP  = 4'h5;
  localparam logic [3:0] PORT_TYPE_DN  = 4'h6;
  localparam logic [2:0] MPS_SUP_SMALL = 3'h1;
  localparam logic [2:0] MPS_SUP_LARGE = 3'h2;
  localparam logic       RBER_RST      = 1'b1;
  localparam logic [2:0] MPS_RST       = 3'h0;
  localparam logic       AUX_DET_RST   = 1'b1;
  localparam logic [1:0] STRAP_SETTLE  = 2'h3;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } spc_cfg_req_s;

  typedef struct packed {
    logic        done;
    logic        nack;
    logic [15:0] rdata;
  } spc_ee_resp_s;

  typedef struct packed {
    logic       done;
    logic       ok;
    logic       ovr_valid;
    logic       slot_impl;
    logic [2:0] mps_sup;
    logic       rber;
  } spc_autoload_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } spc_spl_msg_s;

endpackage

// [verification/spc_config_regs_properties.sv]
// concurrent checks on the config bank ports
`timescale 1ns/1ps
module spc_config_regs_properties #(
  parameter bit IS_UPSTREAM = 1'b1,
  parameter int EE_ADDR_W   = 7
) (
  input wire logic                  clk_in,         // core clock
  input wire logic                  resetn_in,      // fundamental reset
  input wire logic                  ce_in,          // clock enable
  input wire spc_pkg::spc_cfg_req_s cfg_req_in,     // config access
  input wire logic [31:0]           cfg_rdata_out,  // read data
  input wire logic                  cfg_rvalid_out, // read valid
  input wire spc_pkg::spc_ee_resp_s ee_resp_in,     // engine result
  input wire logic                  ee_start_out,   // access request
  input wire logic                  ee_write_out,   // access kind
  input wire logic [EE_ADDR_W-1:0]  ee_addr_out,    // word address
  input wire logic [15:0]           ee_wdata_out,   // write word
  input wire logic [1:0]            ee_rate_out,    // clock rate
  input wire logic                  autoload_disable_out, // autoload off
  input wire logic [3:0]            err_report_en_out, // report enables
  input wire logic [2:0]            max_payload_out // payload size
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic launch, rd_c0, rd_c8, wr_c8;
  assign launch = ce_in && cfg_req_in.wr && cfg_req_in.be[0] && IS_UPSTREAM
    && cfg_req_in.addr == spc_pkg::OFF_EEPROM && cfg_req_in.wdata[0]
    && !ee_start_out;
  assign rd_c0 = ce_in && cfg_req_in.rd && cfg_req_in.addr == 8'hC0;
  assign rd_c8 = ce_in && cfg_req_in.rd && cfg_req_in.addr == 8'hC8;
  assign wr_c8 = ce_in && cfg_req_in.wr && cfg_req_in.addr == 8'hC8
    && cfg_req_in.be[0];
  property p_launch;
    launch |=> ee_start_out && ee_write_out == $past(cfg_req_in.wdata[1]);
  endproperty
  a_launch: assert property (p_launch)
    else $error("access launch wrong");
  property p_addr;
    launch && cfg_req_in.be[1] |=>
      ee_addr_out == $past(cfg_req_in.wdata[15:9]);
  endproperty
  a_addr: assert property (p_addr)
    else $error("eeprom address wrong");
  property p_wdata;
    launch && cfg_req_in.be[3:2] == 2'b11 |=>
      ee_wdata_out == $past(cfg_req_in.wdata[31:16]);
  endproperty
  a_wdata: assert property (p_wdata)
    else $error("eeprom write word wrong");
  property p_hold;
    ee_start_out && !(ce_in && ee_resp_in.done) |=> ee_start_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("access dropped early");
  property p_done;
    ce_in && ee_start_out && ee_resp_in.done |=> !ee_start_out;
  endproperty
  a_done: assert property (p_done)
    else $error("start not cleared at done");
  property p_cap;
    rd_c0 |=> cfg_rvalid_out ##0 cfg_rdata_out[19:0] == 20'h20010
      && cfg_rdata_out[31:25] == 7'h0;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability header wrong");
  property p_type;
    rd_c0 |=> cfg_rdata_out[23:20] == (IS_UPSTREAM ? 4'h5 : 4'h6);
  endproperty
  a_type: assert property (p_type)
    else $error("port type wrong");
  property p_ctl;
    wr_c8 |=> err_report_en_out == $past(cfg_req_in.wdata[3:0])
      && max_payload_out <= $past(cfg_req_in.wdata[7:5]);
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("device control write wrong");
  property p_fixed;
    rd_c8 |=> cfg_rdata_out[21:20] == 2'b01 && cfg_rdata_out[4] == 1'b0
      && cfg_rdata_out[15:11] == 5'h0 && cfg_rdata_out[9:8] == 2'h0;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed control bits wrong");
  property p_rst;
    $rose(resetn_in) |-> ee_rate_out == 2'h1 && autoload_disable_out
      && err_report_en_out == 4'h0 && max_payload_out == 3'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
endmodule
bind spc_config_regs spc_config_regs_properties #(
  .IS_UPSTREAM(IS_UPSTREAM), .EE_ADDR_W(EE_ADDR_W)
) u_props (
  .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
  .cfg_rvalid_out(cfg_rvalid_out), .ee_resp_in(ee_resp_in),
  .ee_start_out(ee_start_out), .ee_write_out(ee_write_out),
  .ee_addr_out(ee_addr_out), .ee_wdata_out(ee_wdata_out),
  .ee_rate_out(ee_rate_out), .autoload_disable_out(autoload_disable_out),
  .err_report_en_out(err_report_en_out), .max_payload_out(max_payload_out)
);

// [verification/spc_ee_model.sv]
// serial eeprom stand-in answering the access engine handshake
`timescale 1ns/1ps
module spc_ee_model (
  input  wire logic             clk_in,   // core clock
  input  wire logic             start_in, // access request
  input  wire logic             write_in, // 1 write, 0 read
  input  wire logic [6:0]       addr_in,  // word address
  input  wire logic [15:0]      wdata_in, // word to store
  input  wire logic             nack_in,  // withhold acknowledge
  input  wire logic [3:0]       lat_in,   // answer delay in cycles
  output spc_pkg::spc_ee_resp_s resp_out  // cycle result
);
  logic [15:0] mem [128];
  int          cnt = -1;
  initial begin
    resp_out = '0;
    foreach (mem[i]) mem[i] = 16'h0;
  end
  // word and nack churn outside done so a stale value never passes
  always @(posedge clk_in) begin
    resp_out.done  <= 1'b0;
    resp_out.nack  <= ~resp_out.nack;
    resp_out.rdata <= ~resp_out.rdata;
    if (!start_in) begin
      cnt <= -1;
    end else if (cnt == -1) begin
      cnt <= int'(lat_in);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      cnt <= -2;
      resp_out.done  <= 1'b1;
      resp_out.nack  <= nack_in;
      resp_out.rdata <= mem[addr_in];
      if (write_in && !nack_in) mem[addr_in] <= wdata_in;
    end
  end
endmodule

// [verification/test_switch_port_config_regs.sv]
// self-checking bench for the switch port config bank
`timescale 1ns/1ps
module test_switch_port_config_regs;
  logic clk_in = 0, resetn_in = 0, por_resetn_in = 0, ce_in = 1;
  logic slot_in = 1, large_in = 1, nack = 0, cfg_rvalid_out, ee_start_out;
  logic ee_write_out, autoload_disable_out, aux_pm_en_out;
  spc_pkg::spc_cfg_req_s  cfg_req_in = '0;
  spc_pkg::spc_autoload_s al_in = '0;
  spc_pkg::spc_spl_msg_s  spl_msg_in = '0;
  spc_pkg::spc_ee_resp_s  ee_resp_in;
  logic [3:0]  err_detect_in = 0, lat = 0, err_report_en_out;
  logic [31:0] cfg_rdata_out, m_bc, m_c0, m_c4, m_c8, seed = 32'hD7FE;
  logic [15:0] ee_wdata_out, ee_mem [int];
  logic [6:0]  ee_addr_out;
  logic [2:0]  max_payload_out;
  logic [1:0]  ee_rate_out;
  int          n_mismatch = 0, compares = 0;
  always #12.5 clk_in = ~clk_in;
  spc_config_regs u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .por_resetn_in(por_resetn_in),
    .ce_in(ce_in), .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out), .ee_resp_in(ee_resp_in),
    .ee_start_out(ee_start_out), .ee_write_out(ee_write_out),
    .ee_addr_out(ee_addr_out), .ee_wdata_out(ee_wdata_out),
    .ee_rate_out(ee_rate_out), .autoload_disable_out(autoload_disable_out),
    .al_in(al_in), .spl_msg_in(spl_msg_in), .err_detect_in(err_detect_in),
    .slot_present_strap_in(slot_in), .large_payload_strap_in(large_in),
    .err_report_en_out(err_report_en_out),
    .max_payload_out(max_payload_out), .aux_pm_en_out(aux_pm_en_out));
  spc_ee_model u_ee (
    .clk_in(clk_in), .start_in(ee_start_out), .write_in(ee_write_out),
    .addr_in(ee_addr_out), .wdata_in(ee_wdata_out), .nack_in(nack),
    .lat_in(lat), .resp_out(ee_resp_in));
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v, b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'hFFFF_FEE3;
    tick;
    cfg_req_in = '{1'b1, 1'b0, a, b[3:0], v};
    tick;
    cfg_req_in.wr = 1'b0;
    if (a == 8'hBC) m_bc = (m_bc & ~m) | (v & m);
    if (a == 8'hBC && b[0] && v[0]) m_bc[2] = 1'b0;
    if (a == 8'hC8 && b[0]) m_c8[3:0] = v[3:0];
    if (a == 8'hC8 && b[0]) m_c8[7:5] = v[7:5] > m_c4[2:0] ? m_c4[2:0] : v[7:5];
    if (a == 8'hC8 && b[1]) m_c8[10] = v[10];
    if (a == 8'hC8 && b[2]) m_c8[19:16] &= ~v[19:16];
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] b);
    logic [31:0] e;
    e = a == 8'hBC ? m_bc : a == 8'hC0 ? m_c0 : a == 8'hC4 ? m_c4 : 32'h0;
    if (a == 8'hC8) e = m_c8;
    tick;
    cfg_req_in = '{1'b0, 1'b1, a, b, 32'h0};
    tick;
    cfg_req_in.rd = 1'b0;
    chk("read valid", cfg_rvalid_out, 1'b1);
    chk($sformatf("read %h", a), cfg_rdata_out, e);
    if (a == 8'hBC && b[0]) m_bc[3] = 1'b0;
  endtask
  task automatic outs;
    chk("report enables", err_report_en_out, m_c8[3:0]);
    chk("payload", max_payload_out, m_c8[7:5]);
    chk("aux enable", aux_pm_en_out, m_c8[10]);
    chk("rate", ee_rate_out, m_bc[7:6]);
    chk("autoload off", autoload_disable_out, m_bc[5]);
  endtask
  task automatic do_reset(input logic por);
    resetn_in = 1'b0;
    por_resetn_in = !por;
    repeat (20) tick;
    m_bc = 32'h0000_0060;
    m_c0 = {7'h0, slot_in, 24'h52_0010};
    m_c4 = 32'h0000_8000 | (large_in ? 32'h2 : 32'h1);
    m_c8 = {11'h0, 1'b1, 9'h0, por ? 1'b0 : m_c8[10], 10'h0};
    resetn_in = 1'b1;
    por_resetn_in = 1'b1;
    repeat (3) tick;
  endtask
  task automatic ee_go(input logic [31:0] v, input logic nk);
    int n;
    nack = nk;
    lat = seed[3:0];
    wr(8'hBC, v, 4'hF);
    chk("start", ee_start_out, 1'b1);
    chk("command", ee_write_out, v[1]);
    chk("address", ee_addr_out, v[15:9]);
    chk("write word", ee_wdata_out, v[31:16]);
    n = 0;
    while (ee_start_out && n < 40) begin
      tick;
      n++;
    end
    chk("finished", ee_start_out, 1'b0);
    m_bc[0] = 1'b0;
    m_bc[2] = nk;
    if (!v[1]) m_bc[31:16] = ee_mem[v[15:9]];
    else if (!nk) ee_mem[v[15:9]] = v[31:16];
    rd(8'hBC, 4'h0);
  endtask
  task automatic al_done(input logic ok);
    al_in = '{1'b1, ok, 1'b0, 1'b0, 3'h0, 1'b0};
    tick;
    al_in = '0;
    m_bc[4] = ok && !m_bc[5];
    if (ok && !m_bc[5]) m_bc[3] = 1'b1;
    rd(8'hBC, 4'h1);
    rd(8'hBC, 4'h1);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    do_reset(1'b1);
    for (int i = 0; i < 5; i++) rd(8'hBC + 8'(i * 4), 4'h0);
    outs;
    // flags are set and cleared in separate cycles; same-cycle race untested
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      err_detect_in = seed[3:0];
      tick;
      err_detect_in = 4'h0;
      m_c8[19:16] |= seed[3:0];
      wr(8'hC8, seed, {28'h0, seed[7:4]});
      outs;
      rd(8'hC8, 4'h0);
    end
    seed = lfsr(seed);
    spl_msg_in = '{1'b1, seed[7:0], seed[9:8]};
    tick;
    spl_msg_in.valid = 1'b0;
    m_c4[27:18] = seed[9:0];
    rd(8'hC4, 4'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ee_go({seed[31:16], seed[15:9], 9'h063}, 1'b0);
      ee_go({16'h0, seed[15:9], 9'h061}, 1'b0);
      ee_go({~seed[31:16], seed[15:9], 9'h063}, 1'b1);
    end
    wr(8'hBC, 32'h0000_0040, 4'h1);
    al_done(1'b1);
    wr(8'hBC, 32'h0000_0060, 4'h1);
    al_done(1'b1);
    al_in = '{1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 1'b0};
    tick;
    al_in = '0;
    m_c0[24] = 1'b0;
    m_c4[2:0] = 3'h1;
    m_c4[15] = 1'b0;
    for (int i = 0; i < 2; i++) rd(8'hC0 + 8'(i * 4), 4'h0);
    wr(8'hC8, 32'h0000_04E0, 4'h3);
    outs;
    {ce_in, err_detect_in} = 5'h0F;
    tick;
    {ce_in, err_detect_in} = 5'h10;
    rd(8'hC8, 4'h0);
    slot_in = 1'b0;
    large_in = 1'b0;
    do_reset(1'b0);
    for (int i = 0; i < 3; i++) rd(8'hC0 + 8'(i * 4), 4'h0);
    outs;
    report_and_stop;
  end
endmodule
